// >>> hdl/spz_pkg.sv
/*
  Constants, register map and state types of the serial port zero block.
  Assumes a 100 MHz system clock used as the oscillator clock of the port.
*/
// Notes on behaviour
// - Control bit 7 is mode bit zero or frame error, chosen by frame_error_select.
// - Frame error sets on a bad stop bit and holds until software clears.
// - Mode 00 sync 8-bit, 01 async 10-bit, 10 async 11-bit, 11 variable 11-bit.
// - Modes 2/3 with multiprocessor_enable: no receive flag when ninth bit is zero.
// - Mode 1 with multiprocessor_enable: no receive flag without a valid stop.
// - Mode 0 shift clock is oscillator/12, or oscillator/4 with multiprocessor_enable.
// - Reception only starts while receive enable is one; only async reception stops when it clears.
// - Modes 2/3 send transmit_ninth_bit as ninth data bit.
// - received_ninth_bit holds ninth bit (2/3), stop bit (mode 1, no multiproc).
// - Transmit flag sets after bit 8 in mode 0, at stop start otherwise.
// - Receive flag sets after bit 8 in mode 0, mid stop otherwise.
// - Data buffer reads give receive register, writes load transmit buffer.
package spz_pkg;

  // ==========================================================
  // Register indices (byte address is four times the index)
  localparam logic [7:0] SPZ_IDX_CONTROL = 8'h98;
  localparam logic [7:0] SPZ_IDX_DATA = 8'h99;
  localparam logic [7:0] SPZ_IDX_POWER = 8'h9A;
  localparam logic [7:0] SPZ_IDX_BAUD = 8'h9B;
  localparam logic [7:0] SPZ_IDX_IRQ_STATUS = 8'h9C;
  localparam logic [7:0] SPZ_IDX_IRQ_MASK = 8'h9D;

  // ==========================================================
  // Field positions
  localparam int SPZ_CTL_MODE0_FE = 7;
  localparam int SPZ_CTL_MODE1 = 6;
  localparam int SPZ_CTL_MPE = 5;
  localparam int SPZ_CTL_REN = 4;
  localparam int SPZ_CTL_TB8 = 3;
  localparam int SPZ_CTL_RB8 = 2;
  localparam int SPZ_CTL_TI = 1;
  localparam int SPZ_CTL_RI = 0;
  localparam int SPZ_PWR_FES = 7;
  localparam int SPZ_PWR_DOUBLE = 6;
  localparam int SPZ_IRQ_RX = 0;
  localparam int SPZ_IRQ_TX = 1;
  localparam int SPZ_IRQ_FE = 2;

  // ==========================================================
  // Reset values
  localparam logic [7:0] SPZ_RST_CONTROL = 8'h00;
  localparam logic [7:0] SPZ_RST_POWER = 8'h00;
  localparam logic [7:0] SPZ_RST_BAUD = 8'h0F;
  localparam logic [2:0] SPZ_RST_IRQ = 3'h0;

  // ==========================================================
  // Timing: tick periods minus one, in system clocks
  localparam logic [7:0] SPZ_M0_SLOW_HALF_M1 = 8'h05; // 12 clocks a bit
  localparam logic [7:0] SPZ_M0_FAST_HALF_M1 = 8'h01; // 4 clocks a bit
  localparam logic [7:0] SPZ_M2_SLOW_TICK_M1 = 8'h03; // 64 clocks a bit
  localparam logic [7:0] SPZ_M2_FAST_TICK_M1 = 8'h01; // 32 clocks a bit
  localparam logic [3:0] SPZ_TICKS_LAST = 4'hF; // 16 ticks a bit
  localparam logic [3:0] SPZ_TICK_MID = 4'h8;
  localparam logic [3:0] SPZ_M0_BITS_LAST = 4'h7;

  // ==========================================================
  // Modes and states
  typedef enum logic [1:0] {
    SPZ_MODE_SYNC = 2'h0,
    SPZ_MODE_ASYNC10 = 2'h1,
    SPZ_MODE_ASYNC11 = 2'h2,
    SPZ_MODE_ASYNC11_VAR = 2'h3
  } spz_mode_t;

  typedef enum logic [2:0] {
    SPZ_TX_IDLE = 3'h0,
    SPZ_TX_SHIFT0 = 3'h1,
    SPZ_TX_START = 3'h2,
    SPZ_TX_DATA = 3'h3,
    SPZ_TX_STOP = 3'h4
  } spz_tx_state_t;

  typedef enum logic [1:0] {
    SPZ_RX_IDLE = 2'h0,
    SPZ_RX_START = 2'h1,
    SPZ_RX_DATA = 2'h2,
    SPZ_RX_STOP = 2'h3
  } spz_rx_state_t;

endpackage : spz_pkg

// >>> hdl/spz_tick_gen.sv
/*
  Programmable divider giving a one-cycle enable pulse.
  Assumes the period input changes only between frames.
*/
`timescale 1ns/1ps
`default_nettype none
module spz_tick_gen #(
  parameter int WIDTH = 8
) (
  input wire logic clock,
  input wire logic nrst,
  input wire logic [WIDTH-1:0] period_m1,
  output logic tick
);

  typedef struct packed {
    logic [WIDTH-1:0] cnt;
    logic tick;
  } spz_div_t;

  spz_div_t st_ff;
  spz_div_t nxt_st;

  // ==========================================================
  // Count up to period, pulse on wrap
  always_comb begin
    nxt_st = st_ff;
    nxt_st.tick = 1'b0;
    if (st_ff.cnt >= period_m1) begin
      nxt_st.cnt = '0;
      nxt_st.tick = 1'b1;
    end else begin
      nxt_st.cnt = st_ff.cnt + 1'b1;
    end
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign tick = st_ff.tick;

endmodule : spz_tick_gen
`default_nettype wire

// >>> hdl/spz_vote.sv
/*
  Three-sample majority vote of the receive line, one sample per tick.
  Assumes the line is already synchronous to the clock.
*/
`timescale 1ns/1ps
`default_nettype none
module spz_vote (
  input wire logic clock,
  input wire logic nrst,
  input wire logic tick,
  input wire logic line_in,
  output logic voted
);

  typedef struct packed {
    logic [2:0] smp;
  } spz_vote_t;

  spz_vote_t st_ff;
  spz_vote_t nxt_st;

  // ==========================================================
  // Shift in on tick; idle line is high
  always_comb begin
    nxt_st = st_ff;
    if (tick) begin
      nxt_st.smp = {st_ff.smp[1:0], line_in};
    end
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      st_ff <= 3'h7;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // Two of three filters single-tick glitches
  assign voted = (st_ff.smp[0] & st_ff.smp[1]) |
                 (st_ff.smp[1] & st_ff.smp[2]) |
                 (st_ff.smp[0] & st_ff.smp[2]);

endmodule : spz_vote
`default_nettype wire

// >>> hdl/spz_serial_port.sv
/*
  Serial port zero: control/status, data buffers, four modes, Avalon-MM
  slave with waitrequest and a masked level interrupt.
  Assumes pins and bus signals are synchronous to clock; address is the
  word index of a register.
*/
// The Avalon-MM interface to the registers was left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module spz_serial_port
  import spz_pkg::*;
(
  input wire logic clock,
  input wire logic nrst,
  input wire logic [7:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] writedata,
  input wire logic [3:0] byteenable,
  output logic [31:0] readdata,
  output logic waitrequest,
  input wire logic rxd_in,
  output logic rxd_out,
  output logic rxd_oe,
  output logic txd_out,
  output logic irq
);

  // ==========================================================
  // State of the whole block
  typedef struct packed {
    logic sm0;
    logic sm1;
    logic mpe;
    logic ren;
    logic tb8;
    logic rb8;
    logic ti;
    logic ri;
    logic fe;
    logic fes;
    logic dbl;
    logic [7:0] baud;
    logic [2:0] ists;
    logic [2:0] imask;
    logic [7:0] rxbuf;
    logic [7:0] txbuf;
    logic txgo;
    spz_tx_state_t tst;
    logic m0rx;
    logic [3:0] tcnt;
    logic [3:0] tbit;
    logic [8:0] tsh;
    spz_rx_state_t rst;
    logic [3:0] rcnt;
    logic [3:0] rbit;
    logic [8:0] rsh;
    logic rprev;
    logic txd;
    logic rxo;
    logic rxoe;
    logic irq;
    logic wreq;
    logic [31:0] rdata;
  } spz_state_t;

  spz_state_t st_ff;
  spz_state_t nxt_st;
  logic tick;
  logic voted;
  logic [7:0] period_m1;

  // ==========================================================
  // Helpers
  function automatic logic [7:0] spz_period(input logic [1:0] mode,
      input logic mpe, input logic dbl, input logic [7:0] baud);
    case (mode)
      SPZ_MODE_SYNC: spz_period = mpe ? SPZ_M0_FAST_HALF_M1 :
                                        SPZ_M0_SLOW_HALF_M1;
      SPZ_MODE_ASYNC11: spz_period = dbl ? SPZ_M2_FAST_TICK_M1 :
                                           SPZ_M2_SLOW_TICK_M1;
      default: spz_period = baud;
    endcase
  endfunction : spz_period

  function automatic logic [7:0] spz_control(input spz_state_t s);
    spz_control = {s.fes ? s.fe : s.sm0, s.sm1, s.mpe, s.ren,
                   s.tb8, s.rb8, s.ti, s.ri};
  endfunction : spz_control

  // Index of the last data bit: eight data bits, or nine in modes 2 and 3
  function automatic logic [3:0] spz_last_bit(input logic nine);
    spz_last_bit = nine ? SPZ_M0_BITS_LAST + 4'h1 : SPZ_M0_BITS_LAST;
  endfunction : spz_last_bit

  // ==========================================================
  // Mode and tick source
  wire logic [1:0] mode = {st_ff.sm0, st_ff.sm1};
  wire logic ninth = st_ff.sm0; // Modes 2 and 3 carry 9 data bits

  assign period_m1 = spz_period(mode, st_ff.mpe, st_ff.dbl, st_ff.baud);

  spz_tick_gen #(
    .WIDTH(8)
  ) u_tick (
    .clock(clock),
    .nrst(nrst),
    .period_m1(period_m1),
    .tick(tick)
  );

  spz_vote u_vote (
    .clock(clock),
    .nrst(nrst),
    .tick(tick),
    .line_in(rxd_in),
    .voted(voted)
  );

  // ==========================================================
  // Next state
  always_comb begin
    logic acc;
    logic wlane;
    logic ev_rx;
    logic ev_tx;
    logic ev_fe;
    logic keep;
    logic stopb;
    acc = 1'b0;
    wlane = 1'b0;
    ev_rx = 1'b0;
    ev_tx = 1'b0;
    ev_fe = 1'b0;
    keep = 1'b0;
    stopb = 1'b0;
    nxt_st = st_ff;
    nxt_st.rprev = rxd_in;

    // Bus: one wait cycle, then the request is taken at the low edge
    acc = (read | write) & ~st_ff.wreq;
    nxt_st.wreq = ~((read | write) & st_ff.wreq);
    nxt_st.rdata = 32'h0000_0000;
    if (read && st_ff.wreq) begin
      case (address)
        SPZ_IDX_CONTROL: nxt_st.rdata[7:0] = spz_control(st_ff);
        SPZ_IDX_DATA: nxt_st.rdata[7:0] = st_ff.rxbuf;
        SPZ_IDX_POWER: nxt_st.rdata[7:0] = {st_ff.fes, st_ff.dbl, 6'h00};
        SPZ_IDX_BAUD: nxt_st.rdata[7:0] = st_ff.baud;
        SPZ_IDX_IRQ_STATUS: nxt_st.rdata[2:0] = st_ff.ists;
        SPZ_IDX_IRQ_MASK: nxt_st.rdata[2:0] = st_ff.imask;
        default: nxt_st.rdata = 32'h0000_0000;
      endcase
    end

    // Software writes, byte lane 0 only
    wlane = acc & write & byteenable[0];
    if (wlane) begin
      case (address)
        SPZ_IDX_CONTROL: begin
          if (st_ff.fes) begin
            nxt_st.fe = writedata[SPZ_CTL_MODE0_FE];
          end else begin
            nxt_st.sm0 = writedata[SPZ_CTL_MODE0_FE];
          end
          nxt_st.sm1 = writedata[SPZ_CTL_MODE1];
          nxt_st.mpe = writedata[SPZ_CTL_MPE];
          nxt_st.ren = writedata[SPZ_CTL_REN];
          nxt_st.tb8 = writedata[SPZ_CTL_TB8];
          nxt_st.rb8 = writedata[SPZ_CTL_RB8];
          nxt_st.ti = writedata[SPZ_CTL_TI];
          nxt_st.ri = writedata[SPZ_CTL_RI];
        end
        SPZ_IDX_DATA: begin
          nxt_st.txbuf = writedata[7:0];
          nxt_st.txgo = 1'b1;
        end
        SPZ_IDX_POWER: begin
          nxt_st.fes = writedata[SPZ_PWR_FES];
          nxt_st.dbl = writedata[SPZ_PWR_DOUBLE];
        end
        SPZ_IDX_BAUD: nxt_st.baud = writedata[7:0];
        SPZ_IDX_IRQ_STATUS: nxt_st.ists = st_ff.ists & ~writedata[2:0];
        SPZ_IDX_IRQ_MASK: nxt_st.imask = writedata[2:0];
        default: nxt_st.baud = st_ff.baud;
      endcase
    end

    // Transmitter, plus both directions of the mode 0 shifter
    case (st_ff.tst)
      SPZ_TX_IDLE: begin
        nxt_st.txd = 1'b1;
        nxt_st.rxoe = 1'b0;
        nxt_st.tcnt = 4'h0;
        nxt_st.tbit = 4'h0;
        if (st_ff.txgo && mode == SPZ_MODE_SYNC) begin
          nxt_st.txgo = 1'b0;
          nxt_st.m0rx = 1'b0;
          nxt_st.tsh = {1'b1, st_ff.txbuf};
          nxt_st.tst = SPZ_TX_SHIFT0;
        end else if (st_ff.txgo) begin
          nxt_st.txgo = 1'b0;
          nxt_st.tsh = {st_ff.tb8, st_ff.txbuf};
          nxt_st.tst = SPZ_TX_START;
        end else if (mode == SPZ_MODE_SYNC && st_ff.ren && !st_ff.ri) begin
          nxt_st.m0rx = 1'b1;
          nxt_st.tst = SPZ_TX_SHIFT0;
        end
      end
      SPZ_TX_SHIFT0: begin
        // Clock low half drives data, high half samples it
        nxt_st.rxoe = ~st_ff.m0rx;
        if (tick && !st_ff.tcnt[0]) begin
          nxt_st.txd = 1'b0;
          nxt_st.rxo = st_ff.tsh[0];
          nxt_st.tcnt = 4'h1;
        end else if (tick) begin
          nxt_st.txd = 1'b1;
          nxt_st.tcnt = 4'h0;
          nxt_st.tsh = {1'b1, st_ff.tsh[8:1]};
          nxt_st.rsh = {rxd_in, st_ff.rsh[8:1]};
          nxt_st.tbit = st_ff.tbit + 4'h1;
          if (st_ff.tbit == SPZ_M0_BITS_LAST) begin
            nxt_st.tst = SPZ_TX_IDLE;
            nxt_st.rxoe = 1'b0;
            if (st_ff.m0rx) begin
              nxt_st.rxbuf = {rxd_in, st_ff.rsh[8:2]};
              ev_rx = 1'b1;
            end else begin
              ev_tx = 1'b1;
            end
          end
        end
      end
      SPZ_TX_START, SPZ_TX_DATA, SPZ_TX_STOP: begin
        nxt_st.rxoe = 1'b0;
        nxt_st.txd = (st_ff.tst == SPZ_TX_START) ? 1'b0 :
                     (st_ff.tst == SPZ_TX_DATA) ? st_ff.tsh[0] : 1'b1;
        if (tick) begin
          nxt_st.tcnt = st_ff.tcnt + 4'h1;
          if (st_ff.tcnt == SPZ_TICKS_LAST) begin
            case (st_ff.tst)
              SPZ_TX_START: nxt_st.tst = SPZ_TX_DATA;
              SPZ_TX_DATA: begin
                nxt_st.tsh = {1'b1, st_ff.tsh[8:1]};
                nxt_st.tbit = st_ff.tbit + 4'h1;
                if (st_ff.tbit == spz_last_bit(ninth)) begin
                  nxt_st.tst = SPZ_TX_STOP;
                  ev_tx = 1'b1;
                end
              end
              default: nxt_st.tst = SPZ_TX_IDLE;
            endcase
          end
        end
      end
      default: nxt_st.tst = SPZ_TX_IDLE;
    endcase

    // Asynchronous receiver, oversampled sixteen times a bit
    case (st_ff.rst)
      SPZ_RX_IDLE: begin
        nxt_st.rcnt = 4'h0;
        nxt_st.rbit = 4'h0;
        if (mode != SPZ_MODE_SYNC && st_ff.ren && st_ff.rprev &&
            !rxd_in) begin
          nxt_st.rst = SPZ_RX_START;
        end
      end
      default: begin
        if (!st_ff.ren) begin
          nxt_st.rst = SPZ_RX_IDLE;
        end else if (tick) begin
          nxt_st.rcnt = st_ff.rcnt + 4'h1;
          if (st_ff.rcnt == SPZ_TICK_MID) begin
            case (st_ff.rst)
              SPZ_RX_START: begin
                // A high start sample is noise, not a frame
                if (voted) begin
                  nxt_st.rst = SPZ_RX_IDLE;
                end
              end
              SPZ_RX_DATA: nxt_st.rsh = {voted, st_ff.rsh[8:1]};
              default: begin
                stopb = voted;
                ev_fe = ~voted;
                if (mode == SPZ_MODE_ASYNC10) begin
                  keep = ~st_ff.mpe | voted;
                end else begin
                  keep = ~st_ff.mpe | st_ff.rsh[8];
                end
                if (keep) begin
                  ev_rx = 1'b1;
                  nxt_st.rxbuf = ninth ? st_ff.rsh[7:0] :
                                         st_ff.rsh[8:1];
                  if (ninth) begin
                    nxt_st.rb8 = st_ff.rsh[8];
                  end else if (!st_ff.mpe) begin
                    nxt_st.rb8 = stopb;
                  end
                end
                nxt_st.rst = SPZ_RX_IDLE;
              end
            endcase
          end else if (st_ff.rcnt == SPZ_TICKS_LAST) begin
            if (st_ff.rst == SPZ_RX_START) begin
              nxt_st.rst = SPZ_RX_DATA;
            end else if (st_ff.rst == SPZ_RX_DATA) begin
              nxt_st.rbit = st_ff.rbit + 4'h1;
              if (st_ff.rbit == spz_last_bit(ninth)) begin
                nxt_st.rst = SPZ_RX_STOP;
              end
            end
          end
        end
      end
    endcase

    // Hardware sets win over a clear in the same cycle
    if (ev_rx) begin
      nxt_st.ri = 1'b1;
      nxt_st.ists[SPZ_IRQ_RX] = 1'b1;
    end
    if (ev_tx) begin
      nxt_st.ti = 1'b1;
      nxt_st.ists[SPZ_IRQ_TX] = 1'b1;
    end
    if (ev_fe) begin
      nxt_st.fe = 1'b1;
      nxt_st.ists[SPZ_IRQ_FE] = 1'b1;
    end
    nxt_st.irq = |(nxt_st.ists & nxt_st.imask);
  end

  // ==========================================================
  // State register
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      st_ff <= '0;
      st_ff.baud <= SPZ_RST_BAUD;
      st_ff.sm0 <= SPZ_RST_CONTROL[SPZ_CTL_MODE0_FE];
      st_ff.fes <= SPZ_RST_POWER[SPZ_PWR_FES];
      st_ff.ists <= SPZ_RST_IRQ;
      st_ff.imask <= SPZ_RST_IRQ;
      st_ff.tst <= SPZ_TX_IDLE;
      st_ff.rst <= SPZ_RX_IDLE;
      st_ff.txd <= 1'b1;
      st_ff.rxo <= 1'b1;
      st_ff.rprev <= 1'b1;
      st_ff.wreq <= 1'b1;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // Outputs straight from the state register
  assign readdata = st_ff.rdata;
  assign waitrequest = st_ff.wreq;
  assign rxd_out = st_ff.rxo;
  assign rxd_oe = st_ff.rxoe;
  assign txd_out = st_ff.txd;
  assign irq = st_ff.irq;

endmodule : spz_serial_port
`default_nettype wire

// >>> verification/spz_serial_port_props.sv
/*
  Checker of bus handshake and pin timing of the serial port block.
  Bound to the top module; sees only its ports, one clock domain.
*/
`timescale 1ns/1ps
`default_nettype none
module spz_serial_port_props (
  input wire logic clock,
  input wire logic nrst,
  input wire logic [7:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] writedata,
  input wire logic [3:0] byteenable,
  input wire logic [31:0] readdata,
  input wire logic waitrequest,
  input wire logic rxd_in,
  input wire logic rxd_out,
  input wire logic rxd_oe,
  input wire logic txd_out,
  input wire logic irq
);
  // ==========================================================
  // Clocking and shift clock phases
  default clocking dclk @(posedge clock);
  endclocking
  default disable iff (!nrst);

  // Low phase of the mode 0 shift clock, fast and slow rate
  sequence clk_low_fast;
    !txd_out [*2] ##1 txd_out;
  endsequence
  sequence clk_low_slow;
    !txd_out [*6] ##1 txd_out;
  endsequence

  // ==========================================================
  // Bus answer: one wait state, one cycle of ready
  answer_next_a: assert property (
    (read || write) && waitrequest |=> !waitrequest)
    else $error("bus request not answered in one cycle");
  answer_once_a: assert property (
    !waitrequest |=> waitrequest)
    else $error("ready held longer than one cycle");
  answer_cause_a: assert property (
    !waitrequest |-> $past(read) || $past(write))
    else $error("ready without a request");
  idle_data_a: assert property (
    waitrequest |-> readdata == 32'h0000_0000)
    else $error("read data not cleared outside an answer");
  lane_zero_a: assert property (
    readdata[31:8] == 24'h00_0000)
    else $error("upper read data lanes not zero");

  // ==========================================================
  // Mode 0 shift clock and data
  shift_clock_a: assert property (
    $fell(txd_out) && rxd_oe |-> clk_low_fast or clk_low_slow)
    else $error("shift clock low phase of wrong length");
  shift_data_a: assert property (
    rxd_oe && $past(rxd_oe) && $changed(rxd_out) |-> !txd_out)
    else $error("shift data changed while clock high");
  // Outputs idle right after reset release
  reset_state_a: assert property (
    $rose(nrst) |-> txd_out && rxd_out && !rxd_oe && !irq && waitrequest)
    else $error("outputs not idle after reset");
endmodule : spz_serial_port_props

bind spz_serial_port spz_serial_port_props props_i (
  .clock(clock), .nrst(nrst), .address(address), .read(read),
  .write(write), .writedata(writedata), .byteenable(byteenable),
  .readdata(readdata), .waitrequest(waitrequest), .rxd_in(rxd_in),
  .rxd_out(rxd_out), .rxd_oe(rxd_oe), .txd_out(txd_out), .irq(irq)
);
`default_nettype wire

// >>> verification/spz_remote_model.sv
/*
  Remote serial device on the far end of the asynchronous line.
  Assumes the bench calls its tasks; bit length given in clocks.
*/
`timescale 1ns/1ps
`default_nettype none
module spz_remote_model (
  input wire logic clock,
  input wire logic line_in,
  output logic line_out
);
  // Line idles high between frames, like a pulled-up wire
  initial line_out = 1'b1;

  // ==========================================================
  // Send start bit, then nb bits LSB first, then idle
  task automatic send(input int bitclk, input int nb,
                      input logic [9:0] bits);
    int i;
    @(posedge clock);
    line_out <= 1'b0;
    repeat (bitclk) @(posedge clock);
    for (i = 0; i < nb; i++) begin
      line_out <= bits[i];
      repeat (bitclk) @(posedge clock);
    end
    line_out <= 1'b1;
    repeat (bitclk) @(posedge clock);
  endtask : send

  // Hold the line at one level, as mode 0 data seen by the block
  task automatic level(input logic v);
    line_out <= v;
  endtask : level

  // Catch a frame, sampling each bit at its middle
  task automatic recv(input int bitclk, input int nb,
                      output logic [9:0] bits);
    int i;
    bits = '1;
    @(posedge clock);
    while (line_in !== 1'b0) @(posedge clock);
    repeat (bitclk / 2) @(posedge clock);
    for (i = 0; i < nb; i++) begin
      repeat (bitclk) @(posedge clock);
      bits[i] = line_in;
    end
  endtask : recv
endmodule : spz_remote_model
`default_nettype wire

// >>> verification/spz_serial_port_tb.sv
/*
  Self-checking bench of the serial port block over Avalon-MM.
  Assumes the remote model on the line and one 100 MHz clock.
*/
`timescale 1ns/1ps
`default_nettype none
module spz_serial_port_tb
  import spz_pkg::*;
();
  logic clock = 1'b0;
  logic nrst = 1'b0;
  logic [7:0] address = 8'h00;
  logic read = 1'b0;
  logic write = 1'b0;
  logic [31:0] writedata = 32'h0000_0000;
  logic [3:0] byteenable = 4'h1;
  wire [31:0] readdata;
  wire waitrequest, rxd_out, rxd_oe, txd_out, irq, remote_line, rxd_line;
  int bad_count = 0;
  int compares = 0;
  // Reset values, transmit and receive tables
  logic [7:0] rst_a [6] = '{8'h98, 8'h9A, 8'h9B, 8'h9C, 8'h9D, 8'h00};
  logic [7:0] rst_v [6] = '{8'h00, 8'h00, 8'h0F, 8'h00, 8'h00, 8'h00};
  logic [7:0] tx_c [3] = '{8'h50, 8'hD8, 8'h90};
  int tx_k [3] = '{16, 16, 64};
  int tx_n [3] = '{9, 10, 10};
  logic [7:0] tx_d [3] = '{8'hA5, 8'hC3, 8'h5A};
  logic [9:0] tx_e [3] = '{10'h3A5, 10'h3C3, 10'h25A};
  logic [7:0] rx_c [4] = '{8'h50, 8'h40, 8'hF0, 8'hF0};
  int rx_n [4] = '{9, 9, 10, 10};
  logic [9:0] rx_b [4] = '{10'h13C, 10'h111, 10'h222, 10'h344};
  logic [7:0] rx_x [4] = '{8'h55, 8'h40, 8'hF0, 8'hF5};
  logic [7:0] rx_d [4] = '{8'h3C, 8'h3C, 8'h3C, 8'h44};

  // ==========================================================
  // Clock, line merge and instances
  always #5 clock = ~clock;
  // Data pin seen by the block: its own drive wins while enabled
  assign rxd_line = rxd_oe ? rxd_out : remote_line;

  spz_serial_port dut (
    .clock(clock), .nrst(nrst), .address(address), .read(read),
    .write(write), .writedata(writedata), .byteenable(byteenable),
    .readdata(readdata), .waitrequest(waitrequest), .rxd_in(rxd_line),
    .rxd_out(rxd_out), .rxd_oe(rxd_oe), .txd_out(txd_out), .irq(irq)
  );
  spz_remote_model remote (
    .clock(clock), .line_in(txd_out), .line_out(remote_line)
  );

  // ==========================================================
  // Compare, bus tasks and closing
  task automatic chk(input string nm, input logic [31:0] got,
                     input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      bad_count++;
      $display("ERROR %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk

  // Request held until ready is sampled low at a rising edge
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clock);
    address <= a;
    writedata <= {24'h00_0000, d};
    write <= 1'b1;
    @(posedge clock);
    while (waitrequest !== 1'b0) @(posedge clock);
    write <= 1'b0;
  endtask : wr

  task automatic rc(input logic [7:0] a, input logic [7:0] e);
    @(posedge clock);
    address <= a;
    read <= 1'b1;
    @(posedge clock);
    while (waitrequest !== 1'b0) @(posedge clock);
    chk($sformatf("reg %h", a), readdata, {24'h00_0000, e});
    read <= 1'b0;
  endtask : rc

  task automatic end_of_test();
    $display("Compares %0d mismatches %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : end_of_test

  // Watchdog well beyond the expected run of some 2400 cycles
  initial begin
    repeat (60000) @(posedge clock);
    bad_count++;
    end_of_test();
  end

  // ==========================================================
  // Test sequence
  initial begin
    logic [9:0] bits;
    logic [7:0] sh;
    int i;
    int j;
    repeat (6) @(posedge clock);
    nrst <= 1'b1;
    for (i = 0; i < 6; i++) rc(rst_a[i], rst_v[i]);
    // Shortest bit: one clock a tick, all interrupts unmasked
    wr(SPZ_IDX_BAUD, 8'h00);
    wr(SPZ_IDX_IRQ_MASK, 8'h07);
    // Asynchronous transmit in modes 1, 3 and 2
    for (i = 0; i < 3; i++) begin
      wr(SPZ_IDX_CONTROL, tx_c[i]);
      wr(SPZ_IDX_DATA, tx_d[i]);
      remote.recv(tx_k[i], tx_n[i], bits);
      chk("tx frame", {22'h00_0000, bits}, {22'h00_0000, tx_e[i]});
      rc(SPZ_IDX_CONTROL, tx_c[i] | 8'h02);
      repeat (tx_k[i]) @(posedge clock);
      wr(SPZ_IDX_CONTROL, tx_c[i]);
    end
    // Masking hides a pending event; a one clears it
    chk("irq", {31'h0, irq}, 32'h1);
    wr(SPZ_IDX_IRQ_MASK, 8'h00);
    repeat (2) @(posedge clock);
    chk("irq", {31'h0, irq}, 32'h0);
    rc(SPZ_IDX_IRQ_STATUS, 8'h02);
    wr(SPZ_IDX_IRQ_STATUS, 8'h02);
    rc(SPZ_IDX_IRQ_STATUS, 8'h00);
    wr(SPZ_IDX_IRQ_MASK, 8'h07);
    // Receive: plain, disabled, address filter with ninth bit zero and one
    for (i = 0; i < 4; i++) begin
      wr(SPZ_IDX_CONTROL, rx_c[i]);
      wr(SPZ_IDX_IRQ_STATUS, 8'h07);
      remote.send(16, rx_n[i], rx_b[i]);
      rc(SPZ_IDX_CONTROL, rx_x[i]);
      rc(SPZ_IDX_DATA, rx_d[i]);
    end
    // Bad stop in mode 1 with multiprocessor_enable: error flag, no receive flag
    wr(SPZ_IDX_IRQ_STATUS, 8'h07);
    // Mode 1 is set while bit 7 still reaches mode bit zero
    wr(SPZ_IDX_CONTROL, 8'h70);
    wr(SPZ_IDX_POWER, 8'h80);
    remote.send(16, 9, 10'h077);
    rc(SPZ_IDX_CONTROL, 8'hF0);
    chk("irq", {31'h0, irq}, 32'h1);
    wr(SPZ_IDX_CONTROL, 8'h70);
    rc(SPZ_IDX_CONTROL, 8'h70);
    wr(SPZ_IDX_POWER, 8'h00);
    wr(SPZ_IDX_IRQ_STATUS, 8'h07);
    // Mode 0 shift out, fast then slow clock
    for (j = 0; j < 2; j++) begin
      wr(SPZ_IDX_CONTROL, j == 0 ? 8'h20 : 8'h00);
      wr(SPZ_IDX_DATA, 8'h96);
      for (i = 0; i < 8; i++) begin
        @(posedge txd_out);
        sh[i] = rxd_out;
      end
      chk("shift data", {24'h00_0000, sh}, 32'h0000_0096);
      repeat (16) @(posedge clock);
      rc(SPZ_IDX_CONTROL, j == 0 ? 8'h22 : 8'h02);
    end
    // Mode 0 receive of a held-low line, fast clock
    remote.level(1'b0);
    wr(SPZ_IDX_CONTROL, 8'h30);
    repeat (48) @(posedge clock);
    rc(SPZ_IDX_CONTROL, 8'h31);
    rc(SPZ_IDX_DATA, 8'h00);
    remote.level(1'b1);
    end_of_test();
  end
endmodule : spz_serial_port_tb
`default_nettype wire
